// file: rtl/chab_top.sv
/*
  Host access bridge: direct-mapped path onto the internal process data
  port, the indirect register bank with its data FIFOs, error logging and
  the reset key detector.
  Assumes the serial slave, the process data port and the key strobes
  all run on I_SYS_CLK; the serial framing lies outside.
*/
// Operation
// RL1 - Direct-mapped mode sends host accesses to the port, bank is bypassed.
// RL2 - Direct-mapped read presents address, byte enables and read request.
// RL3 - The port answers each read with acknowledge and data.
// RL4 - Read data is taken from the lane of the byte address.
// RL5 - Direct-mapped write presents address, enables, data, request; waits acknowledge.
// RL6 - Write bytes are placed on lanes chosen by address and enables.
// RL7 - Each detected access error increments a readable error counter.
// RL8 - Cause of the latest access error is readable.
// RL9 - Network key bytes 52h, 45h, 53h in three frames trigger reset.
// RL10 - Host writes 52h, 45h, 53h to its key register to reset.
// RL11 - In direct-mapped mode the indirect bank and FIFOs are inaccessible.
// RL12 - Read FIFO decodes at 000h-01Ch, write FIFO at 020h-03Ch.
// RL13 - Command and address registers sit at 300h through 314h.
// RL14 - Read FIFO is read-only and valid only while its flag is 1.
// RL15 - Host reads the read FIFO only when data is available.
// RL16 - Write FIFO is write-only and words go toward process RAM.
// RL17 - Host writes the write FIFO only while space is flagged.
// RL18 - Lanes outside start address and length are not written.
// RL19 - A count field tells how many FIFO writes may follow.
// RL20 - Direct map: core at 0-FFFh, process RAM at 1000h-2FFFh.
// RL21 - Direct-mapped mode only when the selection field chooses it.
// RL22 - Core command busy stays set until the operation completes.
// RL23 - A wrong key byte restarts the key sequence.
`include "chab_params.svh"
`default_nettype none

// ****************************************************************
// FIFO with valid and ready on both sides.
// ****************************************************************
module chab_fifo #(
  parameter int W = 32,
  parameter int D = 4
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_reset_n,
  input  wire logic                 i_in_valid,
  output logic                      o_in_ready,
  input  wire logic [W-1:0]         i_in_data,
  output logic                      o_out_valid,
  input  wire logic                 i_out_ready,
  output logic [W-1:0]              o_out_data,
  output logic [$clog2(D+1)-1:0]    o_count
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D+1);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [CW-1:0]       cnt;
  } chab_fifo_st_t;
  chab_fifo_st_t r;
  chab_fifo_st_t next_r;
  logic          push;
  logic          pop;

  // Full and empty come straight from the count, so they never lie.
  assign o_in_ready  = (r.cnt != CW'(D));
  assign o_out_valid = (r.cnt != '0);
  assign o_out_data  = r.mem[r.rp];
  assign o_count     = r.cnt;
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  // Pointers wrap at the depth, which is a power of two here.
  always_comb begin
    next_r = r;
    if (push) begin
      next_r.mem[r.wp] = i_in_data;
      next_r.wp        = r.wp + AW'(1);
    end
    if (pop) begin
      next_r.rp = r.rp + AW'(1);
    end
    next_r.cnt = r.cnt + CW'(push) - CW'(pop);
  end

  // Storage registers.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
endmodule

// ****************************************************************
// Bridge top.
// ****************************************************************
module chab_top
  import chab_pkg::*;
(
  input  wire logic           I_SYS_CLK,
  input  wire logic           I_RESET_N,
  input  wire logic           I_DIRECT_MAPPED,
  input  wire logic           I_HOST_REQ,
  input  wire chab_host_req_t I_HOST,
  output logic                O_HOST_BUSY,
  output logic                O_HOST_ACK,
  output logic [31:0]         O_HOST_RDATA,
  input  wire chab_err_t      I_SPI_ERR,
  input  wire logic           I_NET_KEY_WE,
  input  wire logic [7:0]     I_NET_KEY_BYTE,
  output chab_pdp_req_t       O_PDP,
  input  wire logic           I_PDP_ACK,
  input  wire logic [31:0]    I_PDP_RDATA,
  output logic                O_DEVICE_RESET
);
  typedef struct packed {
    chab_state_t   state;
    chab_pdp_req_t pdp;
    logic          host_ack;
    logic [31:0]   host_rdata;
    logic [1:0]    lane;
    logic [31:0]   csr_data;
    logic          indirect_op_busy;
    logic          csr_rnw;
    logic [2:0]    csr_size;
    logic [15:0]   csr_addr;
    logic [15:0]   rd_addr;
    logic [15:0]   rd_len;
    logic          rd_busy;
    logic [15:0]   wr_addr;
    logic [15:0]   wr_len;
    logic          wr_busy;
    logic [7:0]    err_cnt;
    logic [7:0]    err_code;
    logic [1:0]    net_stage;
    logic [1:0]    host_stage;
    logic          dev_reset;
  } chab_regs_t;

  chab_regs_t  r;
  chab_regs_t  next_r;
  logic        wf_push;
  logic        wf_ready;
  logic        wf_valid;
  logic        wf_pop;
  logic [31:0] wf_data;
  logic [2:0]  wf_cnt;
  logic        rf_push;
  logic        rf_ready;
  logic        rf_valid;
  logic        rf_pop;
  logic [31:0] rf_data;
  logic [2:0]  rf_cnt;
  logic [2:0]  wr_space;
  logic        in_rd_win;
  logic        in_wr_win;
  logic        dm_err;

  // ****************************************************************
  // Helper functions.
  // ****************************************************************
  // Bytes a transfer moves in the current word: up to the word end or length.
  function automatic logic [15:0] take_bytes(input logic [1:0] a, input logic [15:0] len);
    logic [15:0] room;
    room = 16'h0004 - {14'h0000, a};
    take_bytes = (len < room) ? len : room;
  endfunction

  // Lanes holding valid bytes of a word, from address and length.
  function automatic logic [3:0] lane_mask(input logic [1:0] a, input logic [15:0] len);
    logic [15:0] t;
    t = take_bytes(a, len);
    lane_mask = 4'h0;
    for (int i = 0; i < 4; i++) begin
      lane_mask[i] = (2'(i) >= a) && ((16'(i) - {14'h0000, a}) < t);
    end
  endfunction

  // Next key detector stage; a wrong byte restarts, a first key byte re-arms.
  function automatic logic [1:0] key_step(input logic [1:0] s, input logic [7:0] b);
    logic [7:0] want;
    want = (s == 2'h0) ? `CHAB_KEY0 : (s == 2'h1) ? `CHAB_KEY1 : `CHAB_KEY2;
    if (b == want && s != 2'h2) begin
      key_step = s + 2'h1;
    end else begin
      key_step = (b == `CHAB_KEY0) ? 2'h1 : 2'h0;
    end
  endfunction

  // ****************************************************************
  // Data FIFOs of the indirect path.
  // ****************************************************************
  chab_fifo #(.W(32), .D(`CHAB_FIFO_DEPTH)) u_wr_fifo (
    .i_clk       (I_SYS_CLK),
    .i_reset_n   (I_RESET_N),
    .i_in_valid  (wf_push),
    .o_in_ready  (wf_ready),
    .i_in_data   (I_HOST.wdata),
    .o_out_valid (wf_valid),
    .i_out_ready (wf_pop),
    .o_out_data  (wf_data),
    .o_count     (wf_cnt)
  );

  chab_fifo #(.W(32), .D(`CHAB_FIFO_DEPTH)) u_rd_fifo (
    .i_clk       (I_SYS_CLK),
    .i_reset_n   (I_RESET_N),
    .i_in_valid  (rf_push),
    .o_in_ready  (rf_ready),
    .i_in_data   (I_PDP_RDATA),
    .o_out_valid (rf_valid),
    .i_out_ready (rf_pop),
    .o_out_data  (rf_data),
    .o_count     (rf_cnt)
  );

  // Decode of the FIFO windows and the free space shown to the host.
  assign in_rd_win = (I_HOST.addr >= `CHAB_RD_FIFO_LO) && (I_HOST.addr <= `CHAB_RD_FIFO_HI); // see RL12
  assign in_wr_win = (I_HOST.addr >= `CHAB_WR_FIFO_LO) && (I_HOST.addr <= `CHAB_WR_FIFO_HI); // see RL12
  assign wr_space  = 3'(`CHAB_FIFO_DEPTH) - wf_cnt; // see RL19

  // ****************************************************************
  // Sequencer and register bank.
  // ****************************************************************
  // Host accesses win over the engines; the engines only run from idle.
  always_comb begin
    next_r           = r;
    next_r.host_ack  = 1'b0;
    next_r.dev_reset = 1'b0;
    wf_push          = 1'b0;
    wf_pop           = 1'b0;
    rf_push          = 1'b0;
    rf_pop           = 1'b0;
    dm_err           = 1'b0;
    // Transfers end on their own once the length is used up.
    if (r.rd_busy && r.rd_len == 16'h0000) begin
      next_r.rd_busy = 1'b0;
    end
    if (r.wr_busy && r.wr_len == 16'h0000) begin
      next_r.wr_busy = 1'b0;
    end
    unique case (r.state)
      ST_IDLE: begin
        if (I_HOST_REQ && I_DIRECT_MAPPED) begin // see RL21 RL11
          if (I_HOST.addr <= `CHAB_DM_RAM_TOP) begin // see RL20
            // Word address out, bytes moved onto their lanes.
            next_r.state     = ST_DM; // see RL1
            next_r.lane      = I_HOST.addr[1:0];
            next_r.pdp.rd    = !I_HOST.wr; // see RL2
            next_r.pdp.wr    = I_HOST.wr; // see RL5
            next_r.pdp.addr  = {I_HOST.addr[15:2], 2'b00};
            next_r.pdp.be    = I_HOST.be << I_HOST.addr[1:0]; // see RL6
            next_r.pdp.wdata = I_HOST.wdata << {I_HOST.addr[1:0], 3'b000}; // see RL6
          end else begin
            next_r.host_ack   = 1'b1;
            next_r.host_rdata = 32'h0000_0000;
            dm_err            = 1'b1;
          end
        end else if (I_HOST_REQ) begin
          next_r.host_ack   = 1'b1;
          next_r.host_rdata = 32'h0000_0000;
          if (!I_HOST.wr) begin
            if (in_rd_win) begin
              // An empty FIFO reads zero and is not popped.
              next_r.host_rdata = rf_valid ? rf_data : 32'h0000_0000; // see RL14
              rf_pop            = rf_valid; // see RL14
            end else begin
              unique case (I_HOST.addr)
                `CHAB_CSR_DATA: next_r.host_rdata = r.csr_data;
                `CHAB_CSR_CMD: next_r.host_rdata = {r.indirect_op_busy, r.csr_rnw, 11'h000,
                                                    r.csr_size, r.csr_addr}; // see RL13
                `CHAB_RD_AL: next_r.host_rdata = {r.rd_len, r.rd_addr};
                `CHAB_RD_CMD: next_r.host_rdata = {r.rd_busy, 20'h00000, rf_cnt,
                                                   7'h00, rf_valid}; // see RL14
                `CHAB_WR_AL: next_r.host_rdata = {r.wr_len, r.wr_addr};
                `CHAB_WR_CMD: next_r.host_rdata = {r.wr_busy, 20'h00000, wr_space,
                                                   7'h00, wf_ready}; // see RL19
                `CHAB_ERR: next_r.host_rdata = {16'h0000, r.err_code, r.err_cnt}; // see RL7
                default: next_r.host_rdata = 32'h0000_0000;
              endcase
            end
          end else if (in_wr_win) begin
            // Words beyond the free space are dropped.
            wf_push = 1'b1; // see RL16
          end else begin
            unique case (I_HOST.addr)
              `CHAB_CSR_DATA: begin
                if (!r.indirect_op_busy) begin
                  next_r.csr_data = I_HOST.wdata;
                end
              end
              `CHAB_CSR_CMD: begin
                if (!r.indirect_op_busy) begin
                  next_r.csr_rnw  = I_HOST.wdata[`CHAB_RNW_BIT];
                  next_r.csr_size = I_HOST.wdata[`CHAB_SIZE_LSB+:3];
                  next_r.csr_addr = I_HOST.wdata[15:0];
                  next_r.indirect_op_busy = I_HOST.wdata[`CHAB_BUSY_BIT]; // see RL22
                end
              end
              `CHAB_RD_AL: begin
                if (!r.rd_busy) begin
                  {next_r.rd_len, next_r.rd_addr} = I_HOST.wdata;
                end
              end
              `CHAB_RD_CMD: begin
                // Built on the next value so a self-clear in this cycle is not undone.
                next_r.rd_busy = (next_r.rd_busy || I_HOST.wdata[`CHAB_BUSY_BIT])
                                 && !I_HOST.wdata[`CHAB_ABORT_BIT];
              end
              `CHAB_WR_AL: begin
                if (!r.wr_busy) begin
                  {next_r.wr_len, next_r.wr_addr} = I_HOST.wdata;
                end
              end
              `CHAB_WR_CMD: begin
                next_r.wr_busy = (next_r.wr_busy || I_HOST.wdata[`CHAB_BUSY_BIT])
                                 && !I_HOST.wdata[`CHAB_ABORT_BIT];
              end
              `CHAB_ERR: next_r.err_cnt = 8'h00;
              `CHAB_HOST_KEY: begin
                next_r.host_stage = key_step(r.host_stage, I_HOST.wdata[7:0]); // see RL23
                next_r.dev_reset  = (r.host_stage == 2'h2)
                                    && (I_HOST.wdata[7:0] == `CHAB_KEY2); // see RL10
              end
              default: ;
            endcase
          end
        end else if (r.indirect_op_busy) begin
          // Core register access, size picks lanes from the low address bits.
          next_r.state     = ST_CSR;
          next_r.pdp.rd    = r.csr_rnw;
          next_r.pdp.wr    = !r.csr_rnw;
          next_r.pdp.addr  = {r.csr_addr[15:2], 2'b00};
          next_r.pdp.be    = lane_mask(r.csr_addr[1:0], {13'h0000, r.csr_size});
          next_r.pdp.wdata = r.csr_data << {r.csr_addr[1:0], 3'b000};
        end else if (r.wr_busy && r.wr_len != 16'h0000 && wf_valid) begin
          // Lanes outside the transfer stay disabled.
          wf_pop           = 1'b1; // see RL16
          next_r.state     = ST_PWR;
          next_r.pdp.wr    = 1'b1;
          next_r.pdp.addr  = {r.wr_addr[15:2], 2'b00};
          next_r.pdp.be    = lane_mask(r.wr_addr[1:0], r.wr_len); // see RL18
          next_r.pdp.wdata = wf_data;
        end else if (r.rd_busy && r.rd_len != 16'h0000 && rf_ready) begin
          // Only start a word when the read FIFO has room for it.
          next_r.state    = ST_PRD;
          next_r.pdp.rd   = 1'b1;
          next_r.pdp.addr = {r.rd_addr[15:2], 2'b00};
          next_r.pdp.be   = 4'hF;
        end
      end
      ST_DM: begin
        if (I_PDP_ACK) begin
          next_r.state      = ST_IDLE;
          next_r.pdp        = '0;
          next_r.host_ack   = 1'b1; // see RL3
          next_r.host_rdata = r.pdp.rd ? (I_PDP_RDATA >> {r.lane, 3'b000}) : 32'h0000_0000; // see RL4
        end
      end
      ST_CSR: begin
        if (I_PDP_ACK) begin
          next_r.state    = ST_IDLE;
          next_r.pdp      = '0;
          next_r.indirect_op_busy = 1'b0; // see RL22
          if (r.csr_rnw) begin
            next_r.csr_data = I_PDP_RDATA >> {r.csr_addr[1:0], 3'b000};
          end
        end
      end
      ST_PRD: begin
        if (I_PDP_ACK) begin
          rf_push        = 1'b1;
          next_r.state   = ST_IDLE;
          next_r.pdp     = '0;
          next_r.rd_addr = r.rd_addr + take_bytes(r.rd_addr[1:0], r.rd_len);
          next_r.rd_len  = r.rd_len - take_bytes(r.rd_addr[1:0], r.rd_len);
        end
      end
      ST_PWR: begin
        if (I_PDP_ACK) begin
          next_r.state   = ST_IDLE;
          next_r.pdp     = '0;
          next_r.wr_addr = r.wr_addr + take_bytes(r.wr_addr[1:0], r.wr_len);
          next_r.wr_len  = r.wr_len - take_bytes(r.wr_addr[1:0], r.wr_len);
        end
      end
      default: begin
        next_r.state = ST_IDLE;
        next_r.pdp   = '0;
      end
    endcase
    // An error in the clearing cycle still counts; the counter saturates.
    if (I_SPI_ERR.err || dm_err) begin
      next_r.err_cnt  = (next_r.err_cnt == 8'hFF) ? 8'hFF : next_r.err_cnt + 8'h01; // see RL7
      next_r.err_code = I_SPI_ERR.err ? I_SPI_ERR.code : `CHAB_ERR_UNMAPPED; // see RL8
    end
    // Each network strobe is one frame of the key sequence.
    if (I_NET_KEY_WE) begin
      next_r.net_stage = key_step(r.net_stage, I_NET_KEY_BYTE); // see RL23
      if (r.net_stage == 2'h2 && I_NET_KEY_BYTE == `CHAB_KEY2) begin
        next_r.dev_reset = 1'b1; // see RL9
      end
    end
  end

  // State register.
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      r <= '{state: ST_IDLE, default: '0};
    end else begin
      r <= next_r;
    end
  end

  // Outputs; busy is combinational so the host never issues mid-transfer.
  assign O_HOST_BUSY    = (r.state != ST_IDLE);
  assign O_HOST_ACK     = r.host_ack;
  assign O_HOST_RDATA   = r.host_rdata;
  assign O_PDP          = r.pdp;
  assign O_DEVICE_RESET = r.dev_reset;

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RESET_N);

  AST_DM_ROUTE: assert property (I_HOST_REQ && !O_HOST_BUSY && I_DIRECT_MAPPED // see RL1
    && I_HOST.addr <= `CHAB_DM_RAM_TOP |=> r.state == ST_DM && !O_HOST_ACK)
    else $error("direct access not routed to port");
  AST_DM_RD_REQ: assert property (I_HOST_REQ && !O_HOST_BUSY && I_DIRECT_MAPPED // see RL2
    && !I_HOST.wr && I_HOST.addr <= `CHAB_DM_RAM_TOP
    |=> O_PDP.rd && O_PDP.addr == {$past(I_HOST.addr[15:2]), 2'b00})
    else $error("read request not presented");
  AST_DM_RD_ACK: assert property (r.state == ST_DM && r.pdp.rd && I_PDP_ACK // see RL4
    |=> O_HOST_ACK && O_HOST_RDATA == ($past(I_PDP_RDATA) >> {$past(r.lane), 3'b000}))
    else $error("read data lane wrong");
  AST_DM_WR_WAIT: assert property (O_PDP.wr && !I_PDP_ACK |=> O_PDP.wr) // see RL5
    else $error("write request dropped before acknowledge");
  AST_DM_WR_LANE: assert property (I_HOST_REQ && !O_HOST_BUSY && I_DIRECT_MAPPED // see RL6
    && I_HOST.wr && I_HOST.addr[1:0] == 2'h2 && I_HOST.addr <= `CHAB_DM_RAM_TOP
    |=> O_PDP.be == {$past(I_HOST.be[1:0]), 2'b00})
    else $error("write lanes wrong");
  AST_ERR_COUNT: assert property (I_SPI_ERR.err && r.err_cnt < 8'hFE // see RL7
    |=> r.err_cnt == $past(r.err_cnt) + 8'h01 || r.err_cnt == 8'h01)
    else $error("error counter not incremented");
  AST_ERR_CODE: assert property (I_SPI_ERR.err |=> r.err_code == $past(I_SPI_ERR.code)) // see RL8
    else $error("error code not recorded");
  AST_NET_KEY: assert property (I_NET_KEY_WE && I_NET_KEY_BYTE == `CHAB_KEY0 // see RL9
    ##1 I_NET_KEY_WE && I_NET_KEY_BYTE == `CHAB_KEY1
    ##1 I_NET_KEY_WE && I_NET_KEY_BYTE == `CHAB_KEY2 |=> O_DEVICE_RESET)
    else $error("network key did not reset");
  AST_BAD_KEY: assert property (I_NET_KEY_WE && I_NET_KEY_BYTE != `CHAB_KEY0 // see RL23
    && I_NET_KEY_BYTE != `CHAB_KEY1 && I_NET_KEY_BYTE != `CHAB_KEY2 |=> r.net_stage == 2'h0)
    else $error("key sequence not restarted");
  AST_RD_EMPTY: assert property (I_HOST_REQ && !O_HOST_BUSY && !I_DIRECT_MAPPED // see RL14
    && !I_HOST.wr && in_rd_win && !rf_valid |=> O_HOST_ACK && O_HOST_RDATA == 32'h0000_0000)
    else $error("empty read FIFO returned data");
  AST_INDIRECT_OP_BUSY: assert property (r.indirect_op_busy && r.state != ST_CSR |=> r.indirect_op_busy) // see RL22
    else $error("busy cleared before completion");
  AST_WR_SPACE: assert property (wf_push && !wf_ready |=> wf_cnt == 3'(`CHAB_FIFO_DEPTH)) // see RL19
    else $error("write FIFO space wrong");

  COV_DM_READ: cover property (r.state == ST_DM && r.pdp.rd && I_PDP_ACK);
  COV_PRAM_WRITE: cover property (r.state == ST_PWR && I_PDP_ACK && r.wr_len != 16'h0000);
  COV_RD_FULL: cover property (r.rd_busy && !rf_ready);
  COV_HOST_KEY: cover property (O_DEVICE_RESET && r.host_stage == 2'h0);
endmodule
`default_nettype wire

// file: rtl/chab_params.svh
/*
  Offsets, field positions, key bytes and sizes for the host access bridge.
  Assumes 16-bit host byte addresses and one 32-bit register per word.
*/
`ifndef CHAB_PARAMS_SVH
`define CHAB_PARAMS_SVH
// Indirect bank offsets.
`define CHAB_RD_FIFO_LO 16'h0000
`define CHAB_RD_FIFO_HI 16'h001C
`define CHAB_WR_FIFO_LO 16'h0020
`define CHAB_WR_FIFO_HI 16'h003C
`define CHAB_CSR_DATA   16'h0300
`define CHAB_CSR_CMD    16'h0304
`define CHAB_RD_AL      16'h0308
`define CHAB_RD_CMD     16'h030C
`define CHAB_WR_AL      16'h0310
`define CHAB_WR_CMD     16'h0314
`define CHAB_ERR        16'h0318
`define CHAB_HOST_KEY   16'h031C
// Direct-mapped space: core registers then process RAM.
`define CHAB_DM_CORE_TOP 16'h0FFF
`define CHAB_DM_RAM_LO   16'h1000
`define CHAB_DM_RAM_TOP  16'h2FFF
// Command register fields.
`define CHAB_BUSY_BIT  31
`define CHAB_RNW_BIT   30
`define CHAB_ABORT_BIT 30
`define CHAB_FLAG_BIT  0
`define CHAB_CNT_LSB   8
`define CHAB_SIZE_LSB  16
// Reset key bytes.
`define CHAB_KEY0 8'h52
`define CHAB_KEY1 8'h45
`define CHAB_KEY2 8'h53
// Misc.
`define CHAB_ERR_UNMAPPED 8'hF0
`define CHAB_FIFO_DEPTH   4
`define CHAB_FIFO_CW      3
`endif

// file: rtl/chab_pkg.sv
/*
  Types of the host access bridge: state codes and request carriers.
  Assumes the constants header is compiled alongside.
*/
`default_nettype none
package chab_pkg;
  // One-hot states of the access sequencer.
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_DM   = 5'h02,
    ST_CSR  = 5'h04,
    ST_PRD  = 5'h08,
    ST_PWR  = 5'h10
  } chab_state_t;
  // Host access as handed over by the serial slave logic.
  typedef struct packed {
    logic        wr;
    logic [15:0] addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } chab_host_req_t;
  // Request toward the internal process data port.
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } chab_pdp_req_t;
  // Error events coming from the serial slave logic.
  typedef struct packed {
    logic       err;
    logic [7:0] code;
  } chab_err_t;
endpackage
`default_nettype wire

// file: tb/chab_pdp_model.sv
/* Process data port model: acks each request, fast or slow.
   Assumes one request at a time from the bridge, same clock. */
`default_nettype none
module chab_pdp_model
  import chab_pkg::*;
(
  input  wire logic          i_clk,
  input  wire logic          i_reset_n,
  input  wire logic          i_slow,
  input  wire chab_pdp_req_t i_req,
  output logic               o_ack,
  output logic [31:0]        o_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] waited;
  // Ack after none or three wait cycles, one ack per request.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      waited <= 2'h0;
      o_ack  <= 1'b0;
    end else begin
      o_ack  <= (i_req.rd | i_req.wr) & !o_ack & (waited == {2{i_slow}});
      waited <= ((i_req.rd | i_req.wr) & !o_ack) ? waited + 2'h1 : 2'h0;
    end
  end
  // Data rides only with the ack, so a late sample sees the inverse.
  assign o_rdata = o_ack ? 32'hA1B2C3D4 : 32'h5E4D3C2B;
endmodule
`default_nettype wire

// file: tb/chab_top_tb_top.sv
/* Self-checking bench of the host access bridge.
   Assumes the port model stands on the far side. */
`default_nettype none
module chab_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import chab_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, dm = 1'b0, req = 1'b0, slow = 1'b0, nwe = 1'b0;
  logic ack, busy, ack_o, dres;
  logic [7:0] nbyte = 8'h00;
  logic [7:0] key[3] = '{8'h52, 8'h45, 8'h53};
  logic [7:0] bad[4] = '{8'h52, 8'h45, 8'h45, 8'h53};
  logic [31:0] rd, prd;
  chab_host_req_t hreq = '0;
  chab_err_t serr = '0;
  chab_pdp_req_t pdp, last;
  int num_errors = 0, n_tests = 0, cyc = 0, n_rst = 0;
  chab_top dut_u (.I_SYS_CLK(clk), .I_RESET_N(rst_n), .I_DIRECT_MAPPED(dm), .I_HOST_REQ(req), .I_HOST(hreq),
    .O_HOST_BUSY(busy), .O_HOST_ACK(ack_o), .O_HOST_RDATA(rd), .I_SPI_ERR(serr), .I_NET_KEY_WE(nwe),
    .I_NET_KEY_BYTE(nbyte), .O_PDP(pdp), .I_PDP_ACK(ack), .I_PDP_RDATA(prd), .O_DEVICE_RESET(dres));
  chab_pdp_model pdp_u (.i_clk(clk), .i_reset_n(rst_n), .i_slow(slow), .i_req(pdp), .o_ack(ack), .o_rdata(prd));
  always #2.5 clk = ~clk;
  // Keep the last port request and count resets; the cycle ceiling cuts a hang.
  always @(posedge clk) begin
    cyc++;
    if (pdp.rd | pdp.wr) last <= pdp;
    if (dres === 1'b1) n_rst <= n_rst + 1;
    if (cyc == 4000) begin
      num_errors++;
      test_done();
    end
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask
  // One host access; entered at a falling edge, returns once answered.
  task automatic host(input logic w, input logic [15:0] a, input logic [3:0] b, input logic [31:0] d);
    int i;
    for (i = 0; i < 20 && busy !== 1'b0; i++) @(negedge clk);
    req = 1'b1;
    hreq = '{w, a, b, d};
    @(negedge clk);
    req = 1'b0;
    for (i = 0; i < 20 && ack_o !== 1'b1; i++) @(negedge clk);
    chk(ack_o, 1'b1);
    @(negedge clk);
  endtask
  task automatic t_fifo();
    int i;
    host(1'b0, 16'h0000, 4'hF, 32'h0);
    chk(rd, 32'h0);
    host(1'b0, 16'h030C, 4'hF, 32'h0);
    chk(rd[0], 1'b0);
    host(1'b1, 16'h0024, 4'hF, 32'hCAFE0123);
    host(1'b0, 16'h0314, 4'hF, 32'h0);
    chk({rd[10:8], rd[0]}, {3'h3, 1'b1});
    host(1'b1, 16'h0310, 4'hF, 32'h00041000);
    host(1'b1, 16'h0314, 4'hF, 32'h80000000);
    for (i = 0; i < 20 && last.wr !== 1'b1; i++) @(negedge clk);
    chk({last.wr, last.addr, last.be, last.wdata}, {1'b1, 16'h1000, 4'hF, 32'hCAFE0123});
    host(1'b1, 16'h0300, 4'hF, 32'h12345678);
    host(1'b0, 16'h0300, 4'hF, 32'h0);
    chk(rd, 32'h12345678);
  endtask
  // Core register read through the command pair, then one process RAM word read.
  task automatic t_indirect();
    int i;
    host(1'b1, 16'h0304, 4'hF, 32'hC0020012);
    host(1'b0, 16'h0300, 4'hF, 32'h0);
    chk({rd, last.rd, last.addr, last.be}, {32'h0000A1B2, 1'b1, 16'h0010, 4'hC});
    host(1'b1, 16'h0308, 4'hF, 32'h00041000);
    host(1'b1, 16'h030C, 4'hF, 32'h80000000);
    for (i = 0; i < 20 && rd[0] !== 1'b1; i++) host(1'b0, 16'h030C, 4'hF, 32'h0);
    chk({rd[10:8], rd[0]}, {3'h1, 1'b1});
    host(1'b0, 16'h0000, 4'hF, 32'h0);
    chk(rd, 32'hA1B2C3D4);
  endtask
  task automatic t_direct();
    dm = 1'b1;
    slow = 1'b1;
    host(1'b0, 16'h1002, 4'h1, 32'h0);
    chk(rd, 32'h0000A1B2);
    chk({last.rd, last.addr, last.be}, {1'b1, 16'h1000, 4'h4});
    slow = 1'b0;
    host(1'b1, 16'h0301, 4'h1, 32'h5A);
    chk({last.wr, last.addr, last.be, last.wdata}, {1'b1, 16'h0300, 4'h2, 32'h00005A00});
  endtask
  task automatic t_error();
    host(1'b0, 16'h3000, 4'h1, 32'h0);
    chk({rd, last.addr}, {32'h0, 16'h0300});
    serr = '{1'b1, 8'h21};
    @(negedge clk);
    serr = '0;
    dm = 1'b0;
    host(1'b0, 16'h0318, 4'hF, 32'h0);
    chk(rd[15:0], 16'h2102);
  endtask
  task automatic t_key();
    foreach (bad[i]) host(1'b1, 16'h031C, 4'h1, {24'h0, bad[i]});
    chk(n_rst, 0);
    foreach (key[i]) host(1'b1, 16'h031C, 4'h1, {24'h0, key[i]});
    chk(n_rst, 1);
    // Network frames back to back, one key byte per cycle.
    foreach (key[i]) begin
      nwe = 1'b1;
      nbyte = key[i];
      @(negedge clk);
    end
    nwe = 1'b0;
    @(negedge clk);
    @(negedge clk);
    chk(n_rst, 2);
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    t_fifo();
    t_indirect();
    t_direct();
    t_error();
    t_key();
    test_done();
  end
endmodule
`default_nettype wire
